// File: pkg/cir_pkg.sv
// constants and types for the interrupt response and register unit
package cir_pkg;
  localparam int CIR_AW = 8;
  // register word offsets
  localparam logic [7:0] OFF_ACT = 8'h00;
  localparam logic [7:0] OFF_SHD = 8'h20;
  localparam logic [7:0] OFF_PAIR = 8'h40;
  localparam logic [7:0] OFF_VBASE = 8'h50;
  localparam logic [7:0] OFF_RFSH = 8'h54;
  localparam logic [7:0] OFF_IDX1 = 8'h58;
  localparam logic [7:0] OFF_IDX2 = 8'h5c;
  localparam logic [7:0] OFF_SP = 8'h60;
  localparam logic [7:0] OFF_PC = 8'h64;
  localparam logic [7:0] OFF_CTRL = 8'h68;
  localparam logic [7:0] OFF_STAT = 8'h6c;
  // control field positions
  localparam int CTL_IRQ_ENABLE_FLAG_PRIMARY = 0;
  localparam int CTL_IRQ_ENABLE_FLAG_SAVED = 1;
  localparam int CTL_IM = 2;
  localparam int CTL_XAF = 8;
  localparam int CTL_XGP = 9;
  localparam int CTL_FETCH = 10;
  // reset values
  localparam logic [7:0] RST8 = 8'h00;
  localparam logic [15:0] RST16 = 16'h0000;
  // interrupt targets and opcodes
  localparam logic [15:0] NMI_VEC = 16'h0066;
  localparam logic [15:0] MODE1_VEC = 16'h0038;
  localparam logic [7:0] OPC_CALL = 8'hcd;
  localparam logic [7:0] RST_MASK = 8'hc7;
  localparam logic [7:0] RST_TGT = 8'h38;
  localparam logic [1:0] IM_ONE = 2'h1;
  localparam logic [1:0] IM_TWO = 2'h2;
  // wait cycles per bus cycle kind
  localparam logic [1:0] BASE_TW = 2'h1;
  localparam logic [1:0] ACK_XTRA_TW = 2'h2;
  localparam logic [1:0] ACK_TW = BASE_TW + ACK_XTRA_TW;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {CYC_FETCH, CYC_ACK, CYC_READ} cir_cyc_t;
endpackage

// File: pkg/cir_bus_if.sv
// cycle request channel and external bus pins between core and sequencer
`timescale 1ns/10ps
interface cir_bus_if;
  import cir_pkg::*;
  logic req;
  cir_cyc_t kind;
  logic [15:0] addr;
  logic [15:0] rfsh_addr;
  logic done;
  logic [7:0] rdata;
  logic [15:0] pin_addr;
  logic fetch_flag;
  logic io_strobe;
  logic mem_strobe;
  logic rd_strobe;
  modport ctl (output req, kind, addr, rfsh_addr, input done, rdata,
    input pin_addr, fetch_flag, io_strobe, mem_strobe, rd_strobe);
  modport seq (input req, kind, addr, rfsh_addr, output done, rdata,
    output pin_addr, fetch_flag, io_strobe, mem_strobe, rd_strobe);
endinterface

// File: hdl/cir_seq.sv
// bus cycle sequencer: opcode fetch, interrupt acknowledge, memory read
`timescale 1ns/10ps
module cir_seq (
  input wire logic i_clk, // core clock
  input wire logic i_rst_n, // synchronised reset, active low
  input wire logic [7:0] i_data, // data bus in
  cir_bus_if.seq bus // cycle requests and pins
);
  import cir_pkg::*;
  typedef enum logic [1:0] {SQ_IDLE, SQ_T2, SQ_T3, SQ_REF} cir_sq_t;
  cir_sq_t st_r;
  cir_cyc_t kind_r;
  logic [1:0] cnt_r;

  // --------------------------------------------------
  // cycle state
  // --------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= SQ_IDLE;
      kind_r <= CYC_FETCH;
      cnt_r <= 2'h0;
    end else begin
      unique case (st_r)
        SQ_IDLE: if (bus.req) begin
          st_r <= SQ_T2;
          kind_r <= bus.kind;
          cnt_r <= (bus.kind == CYC_ACK) ? ACK_TW : BASE_TW;
        end
        SQ_T2: if (cnt_r == 2'h1) begin
          st_r <= SQ_T3;
        end else begin
          cnt_r <= cnt_r - 2'h1;
        end
        SQ_T3: st_r <= (kind_r == CYC_FETCH) ? SQ_REF : SQ_IDLE;
        SQ_REF: st_r <= SQ_IDLE;
      endcase
    end
  end

  // --------------------------------------------------
  // pins and answer
  // --------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus.pin_addr <= RST16;
      bus.fetch_flag <= 1'b0;
      bus.io_strobe <= 1'b0;
      bus.mem_strobe <= 1'b0;
      bus.rd_strobe <= 1'b0;
      bus.rdata <= RST8;
      bus.done <= 1'b0;
    end else begin
      bus.done <= (st_r == SQ_T3 && kind_r != CYC_FETCH) || st_r == SQ_REF;
      if (st_r == SQ_IDLE && bus.req) begin
        bus.pin_addr <= bus.addr;
        bus.fetch_flag <= bus.kind != CYC_READ;
        bus.io_strobe <= bus.kind == CYC_ACK;
        bus.mem_strobe <= bus.kind != CYC_ACK;
        bus.rd_strobe <= bus.kind != CYC_ACK;
      end else if (st_r == SQ_T3) begin
        bus.rdata <= i_data;
        bus.fetch_flag <= 1'b0;
        bus.io_strobe <= 1'b0;
        bus.rd_strobe <= 1'b0;
        bus.mem_strobe <= kind_r == CYC_FETCH;
        if (kind_r == CYC_FETCH) begin
          bus.pin_addr <= bus.rfsh_addr;
        end
      end else if (st_r == SQ_REF) begin
        bus.mem_strobe <= 1'b0;
      end
    end
  end

  // --------------------------------------------------
  // checks
  // --------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_ack_io;
    bus.io_strobe |-> !bus.mem_strobe && bus.fetch_flag;
  endproperty
  a_ack_io: assert property (p_ack_io) else $error("ack cycle drove memory strobe");
  property p_ack_len;
    $rose(bus.io_strobe) |-> bus.io_strobe [*4] ##1 !bus.io_strobe;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack cycle length wrong");
  property p_rfsh_out;
    st_r == SQ_T3 && kind_r == CYC_FETCH |=> bus.pin_addr == $past(bus.rfsh_addr);
  endproperty
  a_rfsh_out: assert property (p_rfsh_out) else $error("refresh address missing");
  property p_rd_len;
    $rose(bus.rd_strobe) |-> bus.mem_strobe ##1 bus.rd_strobe ##1 !bus.rd_strobe;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");
  c_ack: cover property (st_r == SQ_T3 && kind_r == CYC_ACK);
endmodule

// File: hdl/cir_top.sv
// interrupt response unit with programmer-visible register set
`timescale 1ns/10ps
module cir_top (
  input wire logic i_clk, // core clock, 125 MHz
  input wire logic i_resetn, // async reset, active low
  input wire logic [cir_pkg::CIR_AW-1:0] i_s_axi_awaddr, // write address
  input wire logic i_s_axi_awvalid, // write address valid
  output logic o_s_axi_awready, // write address ready
  input wire logic [31:0] i_s_axi_wdata, // write data
  input wire logic [3:0] i_s_axi_wstrb, // write byte strobes
  input wire logic i_s_axi_wvalid, // write data valid
  output logic o_s_axi_wready, // write data ready
  output logic [1:0] o_s_axi_bresp, // write response
  output logic o_s_axi_bvalid, // write response valid
  input wire logic i_s_axi_bready, // write response ready
  input wire logic [cir_pkg::CIR_AW-1:0] i_s_axi_araddr, // read address
  input wire logic i_s_axi_arvalid, // read address valid
  output logic o_s_axi_arready, // read address ready
  output logic [31:0] o_s_axi_rdata, // read data
  output logic [1:0] o_s_axi_rresp, // read response
  output logic o_s_axi_rvalid, // read data valid
  input wire logic i_s_axi_rready, // read data ready
  input wire logic [7:0] i_data, // external data bus
  input wire logic i_nmi_n, // non-maskable request, falling edge
  input wire logic i_int_n, // maskable request, active low level
  input wire logic i_bus_hold_request, // bus hold request, active high
  output logic [15:0] o_addr, // external address bus
  output logic o_opcode_fetch_cycle_flag, // fetch or acknowledge cycle
  output logic o_io_cycle_strobe, // io strobe
  output logic o_memory_cycle_strobe, // memory strobe
  output logic o_rd_strobe // read strobe
);
  import cir_pkg::*;
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_ACK, ST_RD_LO, ST_RD_HI} cir_st_t;

  // --------------------------------------------------
  // reset release
  // --------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // --------------------------------------------------
  // state
  // --------------------------------------------------
  logic [7:0] bank_r [0:15];
  logic af_sel_r, gp_sel_r;
  logic [7:0] vbase_r, r_r, opcode_r, lo_r;
  logic [15:0] idx1_r, idx2_r, sp_r, pc_r, rd_addr_r;
  logic irq_enable_flag_primary_r, irq_enable_flag_saved_r;
  logic [1:0] irq_mode_bits_r;
  logic nmi_prev_r, nmi_pend_r, fetch_pend_r;
  cir_st_t st_r;
  logic [7:0] wa, ra;
  logic [31:0] wd;
  logic [3:0] ws;
  logic wr_go, ctrl_wr, rd_ok;
  logic [31:0] rd_d;
  logic take_nmi, take_int, take_fetch;
  logic ack_done, lo_done, hi_done, fetch_done;
  cir_bus_if bus ();

  // physical bank slot for a byte index; accumulator/flags and
  // general registers follow separate exchange selects
  function automatic logic [3:0] phys(input logic [2:0] idx, input logic shd,
                                      input logic afs, input logic gps);
    logic sel;
    sel = (idx < 3'h2) ? afs : gps;
    phys = {sel ^ shd, idx};
  endfunction

  function automatic logic [15:0] mrg(input logic [15:0] old, input logic [31:0] d,
                                      input logic [3:0] s);
    mrg = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic is_pair(input logic [7:0] a);
    is_pair = a[7:4] == OFF_PAIR[7:4] && a[3:2] != 2'h3;
  endfunction

  function automatic logic [2:0] pair_hi(input logic [7:0] a);
    pair_hi = 3'({a[3:2], 1'b0}) + 3'h2;
  endfunction

  function automatic logic hit(input logic [7:0] a);
    hit = a[1:0] == 2'h0 && (a < OFF_PAIR || is_pair(a) || (a >= OFF_VBASE && a <= OFF_STAT));
  endfunction

  // --------------------------------------------------
  // register bus, write side
  // --------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_s_axi_awready <= 1'b1;
      wa <= RST8;
    end else if (i_s_axi_awvalid && o_s_axi_awready) begin
      o_s_axi_awready <= 1'b0;
      wa <= i_s_axi_awaddr;
    end else if (o_s_axi_bvalid && i_s_axi_bready) begin
      o_s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_s_axi_wready <= 1'b1;
      wd <= 32'h0;
      ws <= 4'h0;
    end else if (i_s_axi_wvalid && o_s_axi_wready) begin
      o_s_axi_wready <= 1'b0;
      wd <= i_s_axi_wdata;
      ws <= i_s_axi_wstrb;
    end else if (o_s_axi_bvalid && i_s_axi_bready) begin
      o_s_axi_wready <= 1'b1;
    end
  end

  assign wr_go = !o_s_axi_awready && !o_s_axi_wready && !o_s_axi_bvalid;
  assign ctrl_wr = wr_go && wa == OFF_CTRL;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp <= hit(wa) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------
  // register bus, read side
  // --------------------------------------------------
  assign ra = i_s_axi_araddr;
  always_comb begin
    rd_ok = hit(ra);
    rd_d = 32'h0;
    if (ra < OFF_PAIR && rd_ok) begin
      rd_d = {24'h0, bank_r[phys(ra[4:2], ra[5], af_sel_r, gp_sel_r)]};
    end else if (is_pair(ra) && rd_ok) begin
      rd_d = {16'h0, bank_r[phys(pair_hi(ra), 1'b0, af_sel_r, gp_sel_r)],
              bank_r[phys(pair_hi(ra) + 3'h1, 1'b0, af_sel_r, gp_sel_r)]};
    end else begin
      case (ra)
        OFF_VBASE: rd_d = {24'h0, vbase_r};
        OFF_RFSH: rd_d = {24'h0, r_r};
        OFF_IDX1: rd_d = {16'h0, idx1_r};
        OFF_IDX2: rd_d = {16'h0, idx2_r};
        OFF_SP: rd_d = {16'h0, sp_r};
        OFF_PC: rd_d = {16'h0, pc_r};
        OFF_CTRL: rd_d = {21'h0, fetch_pend_r, gp_sel_r, af_sel_r, 4'h0, irq_mode_bits_r,
                          irq_enable_flag_saved_r, irq_enable_flag_primary_r};
        OFF_STAT: rd_d = {16'h0, opcode_r, 2'h0, nmi_pend_r, 2'h0, 3'(st_r)};
        default: rd_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0;
      o_s_axi_rresp <= RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= rd_d;
      o_s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_arready <= 1'b1;
    end
  end

  // --------------------------------------------------
  // register banks and 16-bit registers
  // --------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        bank_r[i] <= RST8;
      end
    end else if (wr_go && hit(wa) && wa < OFF_PAIR && ws[0]) begin
      bank_r[phys(wa[4:2], wa[5], af_sel_r, gp_sel_r)] <= wd[7:0];
    end else if (wr_go && hit(wa) && is_pair(wa)) begin
      if (ws[1]) begin
        bank_r[phys(pair_hi(wa), 1'b0, af_sel_r, gp_sel_r)] <= wd[15:8];
      end
      if (ws[0]) begin
        bank_r[phys(pair_hi(wa) + 3'h1, 1'b0, af_sel_r, gp_sel_r)] <= wd[7:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      af_sel_r <= 1'b0;
      gp_sel_r <= 1'b0;
    end else if (ctrl_wr && ws[1]) begin
      af_sel_r <= af_sel_r ^ wd[CTL_XAF];
      gp_sel_r <= gp_sel_r ^ wd[CTL_XGP];
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      vbase_r <= RST8;
      idx1_r <= RST16;
      idx2_r <= RST16;
      sp_r <= RST16;
    end else if (wr_go) begin
      if (wa == OFF_VBASE && ws[0]) begin
        vbase_r <= wd[7:0];
      end
      if (wa == OFF_IDX1) begin
        idx1_r <= mrg(idx1_r, wd, ws);
      end
      if (wa == OFF_IDX2) begin
        idx2_r <= mrg(idx2_r, wd, ws);
      end
      if (wa == OFF_SP) begin
        sp_r <= mrg(sp_r, wd, ws);
      end
    end
  end

  // --------------------------------------------------
  // interrupt recognition
  // --------------------------------------------------
  assign take_nmi = st_r == ST_IDLE && nmi_pend_r && !i_bus_hold_request;
  assign take_int = st_r == ST_IDLE && !nmi_pend_r && !i_int_n &&
                    irq_enable_flag_primary_r && !i_bus_hold_request;
  assign take_fetch = st_r == ST_IDLE && !nmi_pend_r && !take_int && fetch_pend_r;
  assign ack_done = st_r == ST_ACK && bus.done;
  assign lo_done = st_r == ST_RD_LO && bus.done;
  assign hi_done = st_r == ST_RD_HI && bus.done;
  assign fetch_done = st_r == ST_FETCH && bus.done;

  // a new edge wins over the clear of the same cycle
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_prev_r <= 1'b1;
      nmi_pend_r <= 1'b0;
      fetch_pend_r <= 1'b0;
    end else begin
      nmi_prev_r <= i_nmi_n;
      nmi_pend_r <= (nmi_prev_r && !i_nmi_n) || (nmi_pend_r && !take_nmi);
      fetch_pend_r <= (ctrl_wr && ws[1] && wd[CTL_FETCH]) || (fetch_pend_r && !take_fetch);
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_flag_primary_r <= 1'b0;
      irq_enable_flag_saved_r <= 1'b0;
      irq_mode_bits_r <= 2'h0;
    end else begin
      if (take_nmi) begin
        irq_enable_flag_primary_r <= 1'b0;
      end else if (take_int) begin
        irq_enable_flag_primary_r <= 1'b0;
        irq_enable_flag_saved_r <= 1'b0;
      end else if (ctrl_wr && ws[0]) begin
        irq_enable_flag_primary_r <= wd[CTL_IRQ_ENABLE_FLAG_PRIMARY];
        irq_enable_flag_saved_r <= wd[CTL_IRQ_ENABLE_FLAG_SAVED];
      end
      if (ctrl_wr && ws[0]) begin
        irq_mode_bits_r <= wd[CTL_IM+:2];
      end
    end
  end

  // --------------------------------------------------
  // response sequence
  // --------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      bus.req <= 1'b0;
      bus.kind <= CYC_FETCH;
      bus.addr <= RST16;
      rd_addr_r <= RST16;
      lo_r <= RST8;
    end else begin
      bus.req <= 1'b0;
      if (take_int) begin
        st_r <= ST_ACK;
        bus.req <= 1'b1;
        bus.kind <= CYC_ACK;
        bus.addr <= pc_r;
      end else if (take_fetch) begin
        st_r <= ST_FETCH;
        bus.req <= 1'b1;
        bus.kind <= CYC_FETCH;
        bus.addr <= pc_r;
      end else if (ack_done && irq_mode_bits_r == IM_TWO) begin
        st_r <= ST_RD_LO;
        bus.req <= 1'b1;
        bus.kind <= CYC_READ;
        bus.addr <= {vbase_r, bus.rdata};
        rd_addr_r <= {vbase_r, bus.rdata};
      end else if (ack_done && irq_mode_bits_r != IM_ONE && bus.rdata == OPC_CALL) begin
        st_r <= ST_RD_LO;
        bus.req <= 1'b1;
        bus.kind <= CYC_READ;
        bus.addr <= pc_r;
        rd_addr_r <= pc_r;
      end else if (lo_done) begin
        st_r <= ST_RD_HI;
        lo_r <= bus.rdata;
        bus.req <= 1'b1;
        bus.kind <= CYC_READ;
        bus.addr <= rd_addr_r + 16'h1;
      end else if (ack_done || hi_done || fetch_done) begin
        st_r <= ST_IDLE;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= RST16;
      r_r <= RST8;
      opcode_r <= RST8;
    end else begin
      if (take_nmi) begin
        pc_r <= NMI_VEC;
      end else if (ack_done && irq_mode_bits_r == IM_ONE) begin
        pc_r <= MODE1_VEC;
      end else if (ack_done && irq_mode_bits_r != IM_TWO &&
                   (bus.rdata & RST_MASK) == RST_MASK) begin
        pc_r <= {8'h00, bus.rdata & RST_TGT};
      end else if (hi_done) begin
        pc_r <= {bus.rdata, lo_r};
      end else if (fetch_done) begin
        pc_r <= pc_r + 16'h1;
      end else if (wr_go && wa == OFF_PC) begin
        pc_r <= mrg(pc_r, wd, ws);
      end
      if (fetch_done) begin
        r_r <= r_r + 8'h1;
        opcode_r <= bus.rdata;
      end else if (wr_go && wa == OFF_RFSH && ws[0]) begin
        r_r <= wd[7:0];
      end
    end
  end

  // --------------------------------------------------
  // bus sequencer and pins
  // --------------------------------------------------
  assign bus.rfsh_addr = {vbase_r, r_r};
  cir_seq u_seq (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_data(i_data),
    .bus(bus.seq)
  );
  assign o_addr = bus.pin_addr;
  assign o_opcode_fetch_cycle_flag = bus.fetch_flag;
  assign o_io_cycle_strobe = bus.io_strobe;
  assign o_memory_cycle_strobe = bus.mem_strobe;
  assign o_rd_strobe = bus.rd_strobe;

  // --------------------------------------------------
  // checks
  // --------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);
  property p_nmi_vec;
    take_nmi |=> pc_r == NMI_VEC && !irq_enable_flag_primary_r;
  endproperty
  a_nmi_vec: assert property (p_nmi_vec) else $error("nmi target wrong");
  property p_int_gate;
    $rose(bus.req) && bus.kind == CYC_ACK |->
      $past(irq_enable_flag_primary_r) && !$past(i_bus_hold_request);
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("ack while masked");
  property p_iff_clear;
    take_int |=> !irq_enable_flag_primary_r && !irq_enable_flag_saved_r;
  endproperty
  a_iff_clear: assert property (p_iff_clear) else $error("enables kept");
  property p_mode1;
    ack_done && irq_mode_bits_r == IM_ONE |=> pc_r == MODE1_VEC && st_r == ST_IDLE;
  endproperty
  a_mode1: assert property (p_mode1) else $error("mode 1 target wrong");
  property p_mode2_ptr;
    ack_done && irq_mode_bits_r == IM_TWO |=>
      bus.req && bus.addr == {vbase_r, $past(bus.rdata)};
  endproperty
  a_mode2_ptr: assert property (p_mode2_ptr) else $error("table pointer wrong");
  property p_hi_read;
    lo_done |=> bus.req && bus.kind == CYC_READ && bus.addr == rd_addr_r + 16'h1;
  endproperty
  a_hi_read: assert property (p_hi_read) else $error("second read wrong");
  property p_rfsh;
    fetch_done |=> r_r == $past(r_r) + 8'h1;
  endproperty
  a_rfsh: assert property (p_rfsh) else $error("refresh not stepped");
  property p_xchg;
    ctrl_wr && ws[1] && wd[CTL_XAF] |=> af_sel_r != $past(af_sel_r);
  endproperty
  a_xchg: assert property (p_xchg) else $error("exchange ignored");
  c_nmi: cover property (take_nmi);
  c_call: cover property (st_r == ST_RD_LO && irq_mode_bits_r == 2'h0);
  c_mode2: cover property (hi_done && irq_mode_bits_r == IM_TWO);
endmodule

// File: test/cir_periph_model.sv
// peripheral model: raises the request and answers acknowledge and memory reads
`timescale 1ns/10ps
module cir_periph_model (
  input wire logic i_clk, // core clock
  input wire logic [15:0] i_addr, // address bus
  input wire logic i_io, // io strobe
  input wire logic i_mem, // memory strobe
  input wire logic i_raise, // bench wants a request
  input wire logic [7:0] i_ack_byte, // byte given on acknowledge
  output logic o_int_n, // maskable request
  output logic [7:0] o_data // data bus
);
  logic req_n_r = 1'b1;
  logic [7:0] last_r = 8'h00;
  assign o_int_n = req_n_r;
  always_ff @(posedge i_clk) begin
    if (i_io) req_n_r <= 1'b1; // dropped once acknowledged
    else if (i_raise) req_n_r <= 1'b0;
  end
  always_ff @(posedge i_clk) begin
    if (i_io || i_mem) last_r <= o_data;
  end
  always_comb begin
    if (i_io) o_data = i_ack_byte;
    else if (i_mem) o_data = i_addr[7:0] ^ i_addr[15:8] ^ 8'h5a;
    else o_data = ~last_r; // released bus shows no stale value
  end
endmodule

// File: test/cir_top_tb.sv
// self-checking bench for the interrupt response unit
`timescale 1ns/10ps
module cir_top_tb;
  import cir_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic nmi_n = 1'b1, hold = 1'b0, raise = 1'b0, int_n;
  logic [7:0] aa = 8'h00, ar = 8'h00, ackb = 8'h00, data, run = 8'h00, io_len = 8'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic awr, wr_r, bv, arr, rv, ff, io, mem, rds;
  logic [1:0] bresp, rresp;
  logic [15:0] addr;
  int bad_count = 0, n_checks = 0, cyc = 0;
  always #4 clk = ~clk;
  cir_top dut (.i_clk(clk), .i_resetn(rstn), .i_s_axi_awaddr(aa), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wr_r), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry),
    .i_s_axi_araddr(ar), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry), .i_data(data),
    .i_nmi_n(nmi_n), .i_int_n(int_n), .i_bus_hold_request(hold), .o_addr(addr),
    .o_opcode_fetch_cycle_flag(ff), .o_io_cycle_strobe(io), .o_memory_cycle_strobe(mem),
    .o_rd_strobe(rds));
  cir_periph_model peer (.i_clk(clk), .i_addr(addr), .i_io(io), .i_mem(mem), .i_raise(raise),
    .i_ack_byte(ackb), .o_int_n(int_n), .o_data(data));
  // length of the last io strobe burst
  always @(posedge clk) begin
    if (io) run <= run + 8'h01;
    else if (run != 8'h00) begin
      io_len <= run;
      run <= 8'h00;
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    aa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (!bv);
    chk(bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er = RESP_OKAY);
    ar <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    chk(rresp, er);
    chk(rdata, ex);
  endtask
  task automatic raise_int(input logic [7:0] b);
    ackb <= b;
    raise <= 1'b1;
    @(posedge clk);
    raise <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  task automatic t_regs;
    rd(OFF_CTRL, 32'h0);
    wr(OFF_SP, 32'h1234);
    rd(OFF_SP, 32'h1234);
    wr(8'h08, 32'h12);
    wr(8'h0c, 32'h34);
    rd(OFF_PAIR, 32'h1234);
    wr(OFF_ACT, 32'h11);
    wr(OFF_CTRL, 32'h300);
    rd(OFF_SHD, 32'h11);
    wr(8'h4c, 32'h1, RESP_SLVERR);
    rd(8'h4c, 32'h0, RESP_SLVERR);
  endtask
  task automatic t_fetch;
    wr(OFF_CTRL, 32'h400);
    repeat (12) @(posedge clk);
    rd(OFF_RFSH, 32'h1);
    rd(OFF_PC, 32'h1);
    rd(OFF_STAT, 32'h5a00);
  endtask
  task automatic t_mode1;
    wr(OFF_CTRL, 32'h5);
    hold <= 1'b1;
    raise_int(8'h00);
    rd(OFF_PC, 32'h1);
    hold <= 1'b0;
    repeat (20) @(posedge clk);
    rd(OFF_PC, {16'h0, MODE1_VEC});
    chk(io_len, 32'h4);
    rd(OFF_CTRL, 32'h304);
  endtask
  task automatic t_mode2;
    wr(OFF_VBASE, 32'h12);
    rd(OFF_VBASE, 32'h12);
    wr(OFF_CTRL, 32'h9);
    raise_int(8'h40);
    rd(OFF_PC, {16'h0, 8'h41 ^ 8'h12 ^ 8'h5a, 8'h40 ^ 8'h12 ^ 8'h5a});
  endtask
  task automatic t_mode0;
    wr(OFF_CTRL, 32'h1);
    raise_int(8'hcf);
    rd(OFF_PC, 32'h8);
    wr(OFF_CTRL, 32'h1);
    raise_int(OPC_CALL);
    rd(OFF_PC, {16'h0, 8'h09 ^ 8'h5a, 8'h08 ^ 8'h5a});
  endtask
  task automatic t_nmi;
    wr(OFF_CTRL, 32'h3);
    nmi_n <= 1'b0;
    repeat (12) @(posedge clk);
    nmi_n <= 1'b1;
    @(posedge clk);
    rd(OFF_PC, {16'h0, NMI_VEC});
    rd(OFF_CTRL, 32'h302);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_fetch;
    t_mode1;
    t_mode2;
    t_mode0;
    t_nmi;
    tally_and_finish;
  end
endmodule
